// >>> logic/tsce_core.sv
// Ternary search engine: registers, array, search and next-free scan
module tsce_core (
	// Clock and reset
	input  wire logic                core_clk,
	input  wire logic                srst,
	// Command request
	input  wire logic                cmd_valid,
	output logic                     cmd_ready,
	input  wire tsce_pkg::tsce_op_t  cmd_op,
	input  wire tsce_pkg::tsce_tgt_t cmd_tgt,
	input  wire logic                cmd_burst,
	input  wire logic [15:0]         cmd_addr,
	input  wire logic [71:0]         cmd_wdata,
	input  wire logic [1:0]          cmd_width,
	input  wire logic [287:0]        search_key,
	input  wire logic [287:0]        search_gmask,
	// Read answer
	output logic                     rd_valid,
	output logic [71:0]              rd_data,
	// Configuration
	input  wire logic [15:0]         quad_cfg,
	input  wire logic                last_in_cascade,
	input  wire logic                last_on_result_bus,
	// Status
	output logic [1:0]               full_indication,
	// Cascade
	input  wire logic                casc_prior_hit,
	output logic                     casc_hit_out,
	// Result pins
	output logic [23:0]              sram_addr,
	output logic                     sram_ce_n,
	output logic                     sram_we_n,
	output logic                     sram_ale_n,
	output logic                     sram_ctl_oe,
	output logic                     sram_oe_n,
	output logic                     sram_oe_n_oe,
	output logic                     search_success_flag,
	output logic                     search_valid,
	output logic                     flag_oe
);

	typedef enum logic [1:0] {ST_IDLE, ST_SEARCH, ST_SCAN} tsce_state_t;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	// data and local mask arrays
	logic [71:0]  data_q [tsce_pkg::DEPTH];
	logic [71:0]  mask_q [tsce_pkg::DEPTH];
	tsce_state_t  state_q;
	logic [13:0]  scan_q;
	logic [15:0]  rbur_adr_q, wbur_adr_q, nfi_q, hit_idx_q;
	logic [8:0]   rbur_len_q, wbur_len_q;
	logic [1:0]   width_q;
	logic [287:0] key_q, gmask_q;
	logic         full_q, hit_q, done_q, rd_valid_q;
	logic [71:0]  rd_data_q;

	// ------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------
	logic        take, is_reg, rd_arr, rd_reg, wr_arr, wr_reg, learn, search;
	logic        rbur_go, wbur_go, wr_en;
	logic [15:0] rd_addr, wr_addr;

	assign cmd_ready = state_q == ST_IDLE;
	assign take      = cmd_valid & cmd_ready;
	assign is_reg    = cmd_tgt == tsce_pkg::TGT_REG;
	assign rd_arr    = take & cmd_op == tsce_pkg::OP_READ & ~is_reg;
	assign rd_reg    = take & cmd_op == tsce_pkg::OP_READ & is_reg;
	assign wr_arr    = take & cmd_op == tsce_pkg::OP_WRITE & ~is_reg;
	assign wr_reg    = take & cmd_op == tsce_pkg::OP_WRITE & is_reg;
	assign learn     = take & cmd_op == tsce_pkg::OP_LEARN & ~full_q;
	assign search    = take & cmd_op == tsce_pkg::OP_SEARCH;
	// A burst beat with the length spent is not counted
	assign rbur_go   = rd_arr & cmd_burst & rbur_len_q != 9'h000;
	assign wbur_go   = wr_arr & cmd_burst & wbur_len_q != 9'h000;
	assign wr_en     = wr_arr & (~cmd_burst | wbur_go);
	assign rd_addr   = cmd_burst ? rbur_adr_q : cmd_addr;
	assign wr_addr   = learn ? nfi_q : (cmd_burst ? wbur_adr_q : cmd_addr);

	// ------------------------------------------------------------
	// Register read words
	// ------------------------------------------------------------
	logic [71:0] id_word, rbur_word, wbur_word, nfi_word, reg_word, arr_word;

	assign id_word   = {40'h0, tsce_pkg::ID_MAKER, tsce_pkg::ID_DEV, 1'b0,
		tsce_pkg::ID_IMPL, tsce_pkg::ID_REV};
	assign rbur_word = {44'h0, rbur_len_q, 3'h0, rbur_adr_q};
	assign wbur_word = {44'h0, wbur_len_q, 3'h0, wbur_adr_q};
	assign nfi_word  = {56'h0, nfi_q};
	assign reg_word  = cmd_addr[6:0] == tsce_pkg::REG_ID   ? id_word   :
	                   cmd_addr[6:0] == tsce_pkg::REG_RBUR ? rbur_word :
	                   cmd_addr[6:0] == tsce_pkg::REG_WBUR ? wbur_word :
	                   cmd_addr[6:0] == tsce_pkg::REG_NFI  ? nfi_word  : 72'h0;
	assign arr_word  = cmd_tgt == tsce_pkg::TGT_MASK ? mask_q[rd_addr] : data_q[rd_addr];

	// ------------------------------------------------------------
	// Page evaluation, four entries per cycle
	// ------------------------------------------------------------
	logic [1:0]  page_cfg;
	logic [3:0]  ent_hit, ent_free;
	logic        pair0, pair1, page_hit, page_free;
	logic [1:0]  hit_off, free_off;

	assign page_cfg = quad_cfg[{scan_q[tsce_pkg::QSEL_MSB:tsce_pkg::QSEL_LSB], 1'b0} +: 2];

	for (genvar k = 0; k < tsce_pkg::LANES; k++) begin : g_lane
		logic [15:0] ea;
		logic [1:0]  lane;
		assign ea   = {scan_q, 2'(k)};
		assign lane = page_cfg == tsce_pkg::CFG_72  ? 2'h0 :
		              page_cfg == tsce_pkg::CFG_144 ? {1'b0, 1'(k)} : 2'(k);
		tsce_entry_match u_match (
			.key   (key_q[lane*tsce_pkg::W +: tsce_pkg::W]),
			.gmask (gmask_q[lane*tsce_pkg::W +: tsce_pkg::W]),
			.data  (data_q[ea]),
			.mask  (mask_q[ea]),
			.hit   (ent_hit[k])
		);
		// empty flag, even slots only for 144
		assign ent_free[k] = ~data_q[ea][0] & (page_cfg != tsce_pkg::CFG_144 || (k % 2) == 0);
	end

	assign pair0    = ent_hit[0] & ent_hit[1];
	assign pair1    = ent_hit[2] & ent_hit[3];
	assign page_hit = page_cfg == width_q && (
		(page_cfg == tsce_pkg::CFG_72  && |ent_hit) ||
		(page_cfg == tsce_pkg::CFG_144 && (pair0 | pair1)) ||
		(page_cfg == tsce_pkg::CFG_288 && &ent_hit));
	assign hit_off  = page_cfg != tsce_pkg::CFG_72 ? (pair0 || page_cfg == tsce_pkg::CFG_288 ? 2'h0 : 2'h2) :
	                  ent_hit[0] ? 2'h0 : ent_hit[1] ? 2'h1 : ent_hit[2] ? 2'h2 : 2'h3;
	assign page_free = |ent_free;
	assign free_off  = ent_free[0] ? 2'h0 : ent_free[1] ? 2'h1 : ent_free[2] ? 2'h2 : 2'h3;

	// ------------------------------------------------------------
	// Array storage
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst) begin
			for (int i = 0; i < tsce_pkg::DEPTH; i++) begin
				data_q[i] <= 72'h0;
				mask_q[i] <= 72'h0;
			end
		end else if (learn) begin
			data_q[wr_addr] <= cmd_wdata | 72'h1;
			mask_q[wr_addr] <= {tsce_pkg::W{1'b1}};
		end else if (wr_en && cmd_tgt == tsce_pkg::TGT_MASK) begin
			mask_q[wr_addr] <= cmd_wdata;
		end else if (wr_en) begin
			data_q[wr_addr] <= cmd_wdata;
		end
	end

	// ------------------------------------------------------------
	// Burst registers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst) begin
			rbur_adr_q <= tsce_pkg::BUR_RST;
			rbur_len_q <= 9'h000;
			wbur_adr_q <= tsce_pkg::BUR_RST;
			wbur_len_q <= 9'h000;
		end else begin
			if (wr_reg && cmd_addr[6:0] == tsce_pkg::REG_RBUR) begin
				rbur_adr_q <= cmd_wdata[tsce_pkg::ADR_LSB +: 16];
				rbur_len_q <= cmd_wdata[tsce_pkg::LEN_LSB +: tsce_pkg::LEN_W];
			end else if (rbur_go) begin
				rbur_adr_q <= rbur_adr_q + 16'h0001;
				rbur_len_q <= rbur_len_q - 9'h001;
			end
			if (wr_reg && cmd_addr[6:0] == tsce_pkg::REG_WBUR) begin
				wbur_adr_q <= cmd_wdata[tsce_pkg::ADR_LSB +: 16];
				wbur_len_q <= cmd_wdata[tsce_pkg::LEN_LSB +: tsce_pkg::LEN_W];
			end else if (wbur_go) begin
				wbur_adr_q <= wbur_adr_q + 16'h0001;
				wbur_len_q <= wbur_len_q - 9'h001;
			end
		end
	end

	// ------------------------------------------------------------
	// Read answer
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst) begin
			rd_valid_q <= 1'b0;
			rd_data_q  <= 72'h0;
		end else begin
			rd_valid_q <= rd_arr | rd_reg;
			if (rd_arr | rd_reg)
				rd_data_q <= rd_reg ? reg_word : arr_word;
		end
	end

	assign rd_valid = rd_valid_q;
	assign rd_data  = rd_data_q;

	// ------------------------------------------------------------
	// Sequencer: search scan and next-free scan
	// ------------------------------------------------------------
	// Scanning a page per cycle trades search latency for area
	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_q   <= ST_IDLE;
			scan_q    <= 14'h0;
			width_q   <= tsce_pkg::CFG_72;
			key_q     <= 288'h0;
			gmask_q   <= 288'h0;
			hit_q     <= 1'b0;
			hit_idx_q <= 16'h0;
			done_q    <= 1'b0;
			nfi_q     <= 16'h0;
			full_q    <= 1'b0;
		end else begin
			done_q <= 1'b0;
			unique case (state_q)
				ST_IDLE: begin
					scan_q <= 14'h0;
					if (search) begin
						key_q   <= search_key;
						gmask_q <= search_gmask;
						width_q <= cmd_width;
						state_q <= ST_SEARCH;
					end else if (learn || (wr_en && cmd_tgt == tsce_pkg::TGT_DATA)) begin
						state_q <= ST_SCAN;
					end
				end
				ST_SEARCH: begin
					if (page_hit || scan_q == tsce_pkg::PAGE_LAST) begin
						hit_q     <= page_hit;
						hit_idx_q <= {scan_q, hit_off};
						done_q    <= 1'b1;
						state_q   <= ST_IDLE;
					end
					scan_q <= scan_q + 14'h0001;
				end
				ST_SCAN: begin
					if (page_free) begin
						nfi_q   <= {scan_q, free_off};
						full_q  <= 1'b0;
						state_q <= ST_IDLE;
					end else if (scan_q == tsce_pkg::PAGE_LAST) begin
						full_q  <= 1'b1;
						state_q <= ST_IDLE;
					end
					scan_q <= scan_q + 14'h0001;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	assign full_indication = {2{full_q}};

	tsce_result_drive u_drive (
		.core_clk            (core_clk),
		.srst                (srst),
		.done                (done_q),
		.local_hit           (hit_q),
		.index               (hit_idx_q),
		.last_in_cascade     (last_in_cascade),
		.last_on_result_bus  (last_on_result_bus),
		.casc_prior_hit      (casc_prior_hit),
		.casc_hit_out        (casc_hit_out),
		.sram_addr           (sram_addr),
		.sram_ce_n           (sram_ce_n),
		.sram_we_n           (sram_we_n),
		.sram_ale_n          (sram_ale_n),
		.sram_ctl_oe         (sram_ctl_oe),
		.sram_oe_n           (sram_oe_n),
		.sram_oe_n_oe        (sram_oe_n_oe),
		.search_success_flag (search_success_flag),
		.search_valid        (search_valid),
		.flag_oe             (flag_oe)
	);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_id_word;
		@(posedge core_clk) disable iff (srst)
		rd_reg && cmd_addr[6:0] == tsce_pkg::REG_ID
			|=> rd_valid && rd_data[3:0] == tsce_pkg::ID_REV && rd_data[3:0] != 4'h0;
	endproperty
	a_id_word: assert property (p_id_word) else $error("revision field wrong");

	property p_id_maker;
		@(posedge core_clk) disable iff (srst)
		rd_reg && cmd_addr[6:0] == tsce_pkg::REG_ID
			|=> rd_data[31:16] == tsce_pkg::ID_MAKER && rd_data[15:8] == tsce_pkg::ID_DEV;
	endproperty
	a_id_maker: assert property (p_id_maker) else $error("maker or device field wrong");

	property p_rbur_step;
		@(posedge core_clk) disable iff (srst)
		rbur_go |=> rbur_adr_q == $past(rbur_adr_q) + 16'h0001;
	endproperty
	a_rbur_step: assert property (p_rbur_step) else $error("read burst address did not step");

	property p_wbur_step;
		@(posedge core_clk) disable iff (srst)
		wbur_go |=> wbur_adr_q == $past(wbur_adr_q) + 16'h0001 && wbur_len_q == $past(wbur_len_q) - 9'h001;
	endproperty
	a_wbur_step: assert property (p_wbur_step) else $error("write burst did not step");

	property p_len_dec;
		@(posedge core_clk) disable iff (srst)
		rbur_go |=> rbur_len_q == $past(rbur_len_q) - 9'h001;
	endproperty
	a_len_dec: assert property (p_len_dec) else $error("read burst length did not decrement");

	property p_nfi_empty;
		@(posedge core_clk) disable iff (srst)
		state_q == ST_SCAN && page_free |=> state_q == ST_IDLE && !data_q[nfi_q][0] && !full_q;
	endproperty
	a_nfi_empty: assert property (p_nfi_empty) else $error("next free index not empty");

	property p_nfi_even;
		@(posedge core_clk) disable iff (srst)
		state_q == ST_SCAN && page_free && page_cfg == tsce_pkg::CFG_144 |=> !nfi_q[0];
	endproperty
	a_nfi_even: assert property (p_nfi_even) else $error("144-bit next free index odd");

	property p_full;
		@(posedge core_clk) disable iff (srst)
		state_q == ST_SCAN && !page_free && scan_q == tsce_pkg::PAGE_LAST |=> full_indication == 2'h3;
	endproperty
	a_full: assert property (p_full) else $error("full indication not raised");

	property p_hit_done;
		@(posedge core_clk) disable iff (srst)
		state_q == ST_SEARCH && page_hit |=> done_q && hit_q && hit_idx_q[15:2] == $past(scan_q);
	endproperty
	a_hit_done: assert property (p_hit_done) else $error("first hit page not reported");

endmodule

// >>> logic/tsce_entry_match.sv
// Ternary compare of one 72-bit entry against one search lane
module tsce_entry_match (
	// Search operands
	input  wire logic [71:0] key,
	input  wire logic [71:0] gmask,
	// Stored entry
	input  wire logic [71:0] data,
	input  wire logic [71:0] mask,
	// Result
	output logic             hit
);

	logic [71:0] bit_ok;

	assign bit_ok = ~gmask | ~mask | ~(key ^ data);
	assign hit = &bit_ok;

endmodule

// >>> logic/tsce_pkg.sv
// Shared constants and types for the ternary search engine
package tsce_pkg;

	// ------------------------------------------------------------
	// Array geometry
	// ------------------------------------------------------------
	localparam int          W          = 72;
	localparam int          AW         = 16;
	localparam int          DEPTH      = 65536;
	localparam int          PW         = 14;
	localparam int          LANES      = 4;
	localparam logic [13:0] PAGE_LAST  = 14'h3FFF;
	localparam int          QSEL_MSB   = 13;
	localparam int          QSEL_LSB   = 11;

	// ------------------------------------------------------------
	// Identification fields, values are arbitrary
	// ------------------------------------------------------------
	localparam logic [3:0]  ID_REV     = 4'h2;
	localparam logic [2:0]  ID_IMPL    = 3'h5;
	localparam logic [7:0]  ID_DEV     = 8'h5A;
	localparam logic [15:0] ID_MAKER   = 16'h1234;

	// ------------------------------------------------------------
	// Register indices and fields
	// ------------------------------------------------------------
	localparam logic [6:0]  REG_ID     = 7'h30;
	localparam logic [6:0]  REG_RBUR   = 7'h40;
	localparam logic [6:0]  REG_WBUR   = 7'h50;
	localparam logic [6:0]  REG_NFI    = 7'h60;
	localparam int          ADR_LSB    = 0;
	localparam int          LEN_LSB    = 19;
	localparam int          LEN_W      = 9;
	localparam logic [8:0]  LEN_MIN    = 9'h004;
	localparam logic [8:0]  LEN_MAX    = 9'h1FF;
	localparam logic [15:0] BUR_RST    = 16'h0000;

	// ------------------------------------------------------------
	// Quadrant width codes
	// ------------------------------------------------------------
	localparam logic [1:0]  CFG_72     = 2'h0;
	localparam logic [1:0]  CFG_144    = 2'h1;
	localparam logic [1:0]  CFG_288    = 2'h2;
	localparam logic [1:0]  CFG_OFF    = 2'h3;

	// ------------------------------------------------------------
	// Result bus idle address and hit address high byte
	// ------------------------------------------------------------
	localparam logic [23:0] SRAM_IDLE  = 24'hFFFFFF;
	localparam logic [7:0]  SRAM_HI    = 8'h00;

	typedef enum logic [1:0] {
		OP_READ   = 2'h0,
		OP_WRITE  = 2'h1,
		OP_SEARCH = 2'h2,
		OP_LEARN  = 2'h3
	} tsce_op_t;

	typedef enum logic [1:0] {
		TGT_DATA = 2'h0,
		TGT_MASK = 2'h1,
		TGT_REG  = 2'h2
	} tsce_tgt_t;

endpackage

// >>> logic/tsce_result_drive.sv
// Cascade arbitration and result bus drivers
module tsce_result_drive (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        srst,
	// Search outcome
	input  wire logic        done,
	input  wire logic        local_hit,
	input  wire logic [15:0] index,
	// Cascade
	input  wire logic        last_in_cascade,
	input  wire logic        last_on_result_bus,
	input  wire logic        casc_prior_hit,
	output logic             casc_hit_out,
	// Result pins
	output logic [23:0]      sram_addr,
	output logic             sram_ce_n,
	output logic             sram_we_n,
	output logic             sram_ale_n,
	output logic             sram_ctl_oe,
	output logic             sram_oe_n,
	output logic             sram_oe_n_oe,
	output logic             search_success_flag,
	output logic             search_valid,
	output logic             flag_oe
);

	logic win;
	logic taken;

	// first hit down the chain wins
	assign win          = done & local_hit & ~casc_prior_hit;
	assign taken        = done & (local_hit | casc_prior_hit);
	assign casc_hit_out = (done & local_hit) | casc_prior_hit;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			sram_addr           <= tsce_pkg::SRAM_IDLE;
			sram_ce_n           <= 1'b1;
			sram_we_n           <= 1'b1;
			sram_ale_n          <= 1'b1;
			sram_ctl_oe         <= 1'b0;
			sram_oe_n           <= 1'b1;
			sram_oe_n_oe        <= 1'b0;
			search_success_flag <= 1'b0;
			search_valid        <= 1'b0;
			flag_oe             <= 1'b0;
		end else begin
			// last on bus fills idle cycles
			sram_addr           <= win ? {tsce_pkg::SRAM_HI, index} : tsce_pkg::SRAM_IDLE;
			sram_ce_n           <= ~win;
			sram_we_n           <= 1'b1;
			sram_ale_n          <= ~win;
			sram_ctl_oe         <= win | (last_on_result_bus & ~taken);
			sram_oe_n           <= ~taken;
			sram_oe_n_oe        <= last_on_result_bus;
			search_success_flag <= win;
			search_valid        <= done & ~casc_prior_hit & (local_hit | last_in_cascade);
			flag_oe             <= win | (last_in_cascade & ~(done & casc_prior_hit));
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_win_drive;
		@(posedge core_clk) disable iff (srst)
		win |=> flag_oe && search_success_flag && search_valid && sram_ctl_oe && !sram_ce_n;
	endproperty
	a_win_drive: assert property (p_win_drive) else $error("winner did not drive result");

	property p_fail_last;
		@(posedge core_clk) disable iff (srst)
		done && !local_hit && !casc_prior_hit && last_in_cascade
			|=> flag_oe && !search_success_flag && search_valid;
	endproperty
	a_fail_last: assert property (p_fail_last) else $error("miss not reported by last device");

	property p_idle_flags;
		@(posedge core_clk) disable iff (srst)
		!done && last_in_cascade |=> flag_oe && !search_success_flag && !search_valid;
	endproperty
	a_idle_flags: assert property (p_idle_flags) else $error("idle flags not driven low");

	property p_idle_bus;
		@(posedge core_clk) disable iff (srst)
		!done && last_on_result_bus
			|=> sram_ctl_oe && sram_addr == 24'hFFFFFF && sram_ce_n && sram_we_n && sram_ale_n;
	endproperty
	a_idle_bus: assert property (p_idle_bus) else $error("idle result bus not parked");

	property p_loser_quiet;
		@(posedge core_clk) disable iff (srst)
		done && casc_prior_hit |=> !flag_oe && !search_success_flag;
	endproperty
	a_loser_quiet: assert property (p_loser_quiet) else $error("losing device drove flags");

	property p_nowin_bus;
		@(posedge core_clk) disable iff (srst)
		done && !local_hit && !casc_prior_hit && last_on_result_bus
			|=> sram_ctl_oe && sram_ce_n && sram_oe_n_oe;
	endproperty
	a_nowin_bus: assert property (p_nowin_bus) else $error("missed search left bus open");

endmodule

// >>> verification/testbench.sv
// Self-checking bench for the search engine core
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 0, srst = 1, cmd_valid = 0, cmd_burst = 0, nb_hit = 0, last_dev = 1, prior;
	logic cmd_ready, rd_valid, search_success_flag, search_valid, flag_oe, ce_n, oe_n_oe, casc_hit;
	logic ctl_oe, we_n, ale_n, oe_n;
	tsce_pkg::tsce_op_t cmd_op = tsce_pkg::OP_READ;
	tsce_pkg::tsce_tgt_t cmd_tgt = tsce_pkg::TGT_REG;
	logic [15:0] cmd_addr = 16'h0000, quad_cfg = 16'h00E4;
	logic [71:0] cmd_wdata = 72'h0, rd_data;
	logic [1:0] cmd_width = 2'h0, full;
	logic [287:0] key = 288'h0, gmask = {288{1'b1}};
	logic [23:0] sram_addr;
	int num_errors = 0, checked = 0, cycles = 0;
	always #2 core_clk = ~core_clk;
	tsce_casc_model u_nb (.hit_en(nb_hit), .prior_hit(prior));
	tsce_core u_dut (.core_clk(core_clk), .srst(srst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_op(cmd_op), .cmd_tgt(cmd_tgt), .cmd_burst(cmd_burst), .cmd_addr(cmd_addr),
		.cmd_wdata(cmd_wdata), .cmd_width(cmd_width), .search_key(key), .search_gmask(gmask),
		.rd_valid(rd_valid), .rd_data(rd_data), .quad_cfg(quad_cfg), .last_in_cascade(last_dev),
		.last_on_result_bus(last_dev), .full_indication(full), .casc_prior_hit(prior), .casc_hit_out(casc_hit),
		.sram_addr(sram_addr), .sram_ce_n(ce_n), .sram_we_n(we_n), .sram_ale_n(ale_n), .sram_ctl_oe(ctl_oe),
		.sram_oe_n(oe_n), .sram_oe_n_oe(oe_n_oe), .search_success_flag(search_success_flag),
		.search_valid(search_valid), .flag_oe(flag_oe));
	task automatic wrap_up();
		if (num_errors == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [71:0] exp, input logic [71:0] got);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic cmd(input tsce_pkg::tsce_op_t op, input tsce_pkg::tsce_tgt_t tg, input logic b,
		input logic [15:0] a, input logic [71:0] d);
		while (cmd_ready !== 1'b1) begin
			@(posedge core_clk);
			#1;
		end
		@(posedge core_clk);
		cmd_valid <= 1'b1;
		cmd_op    <= op;
		cmd_tgt   <= tg;
		cmd_burst <= b;
		cmd_addr  <= a;
		cmd_wdata <= d;
		@(posedge core_clk);
		cmd_valid <= 1'b0;
		#1;
	endtask
	task automatic rd(input tsce_pkg::tsce_tgt_t tg, input logic b, input logic [15:0] a, input logic [71:0] e);
		cmd(tsce_pkg::OP_READ, tg, b, a, 72'h0);
		chk("rd_valid", 72'h1, {71'h0, rd_valid});
		chk("rd_data", e, rd_data);
	endtask
	task automatic wr(input logic [15:0] a, input logic [71:0] d);
		cmd(tsce_pkg::OP_WRITE, tsce_pkg::TGT_REG, 1'b0, a, d);
	endtask
	task automatic t_id();
		chk("idle_bus", {46'h0, 24'hFFFFFF, 2'h3}, {46'h0, sram_addr, ce_n, oe_n_oe});
		rd(tsce_pkg::TGT_REG, 1'b0, 16'h0030, {40'h0, tsce_pkg::ID_MAKER, tsce_pkg::ID_DEV, 1'b0,
			tsce_pkg::ID_IMPL, tsce_pkg::ID_REV});
		rd(tsce_pkg::TGT_REG, 1'b0, 16'h0070, 72'h0);
	endtask
	task automatic t_burst();
		wr(16'h0050, {44'h0, 9'h004, 3'h0, 16'h0005});
		cmd(tsce_pkg::OP_WRITE, tsce_pkg::TGT_DATA, 1'b1, 16'h0000, 72'h1);
		rd(tsce_pkg::TGT_REG, 1'b0, 16'h0050, {44'h0, 9'h003, 3'h0, 16'h0006});
		rd(tsce_pkg::TGT_REG, 1'b0, 16'h0060, 72'h0);
		wr(16'h0040, {44'h0, 9'h1FF, 3'h0, 16'h0005});
		rd(tsce_pkg::TGT_DATA, 1'b1, 16'h0000, 72'h1);
		rd(tsce_pkg::TGT_REG, 1'b0, 16'h0040, {44'h0, 9'h1FE, 3'h0, 16'h0006});
		cmd(tsce_pkg::OP_WRITE, tsce_pkg::TGT_DATA, 1'b0, 16'h0000, 72'h1);
		rd(tsce_pkg::TGT_REG, 1'b0, 16'h0060, 72'h1);
		chk("full", 72'h0, {70'h0, full});
		cmd(tsce_pkg::OP_WRITE, tsce_pkg::TGT_MASK, 1'b0, 16'h0000, {72{1'b1}});
		cmd(tsce_pkg::OP_LEARN, tsce_pkg::TGT_DATA, 1'b0, 16'h0000, 72'hAB0);
		rd(tsce_pkg::TGT_DATA, 1'b0, 16'h0001, 72'hAB1);
		rd(tsce_pkg::TGT_REG, 1'b0, 16'h0060, 72'h2);
		rd(tsce_pkg::TGT_MASK, 1'b0, 16'h0000, {72{1'b1}});
		// both flags of the 144-bit pair kept equal
		cmd(tsce_pkg::OP_WRITE, tsce_pkg::TGT_DATA, 1'b0, 16'h2000, 72'h1);
		cmd(tsce_pkg::OP_WRITE, tsce_pkg::TGT_DATA, 1'b0, 16'h2001, 72'h1);
	endtask
	task automatic search(input logic [1:0] w, input logic p, input logic l, input logic [2:0] e,
		input logic [23:0] ea, input logic [4:0] pe);
		int i;
		@(posedge core_clk);
		cmd_width <= w;
		nb_hit    <= p;
		last_dev  <= l;
		cmd(tsce_pkg::OP_SEARCH, tsce_pkg::TGT_DATA, 1'b0, 16'h0000, 72'h0);
		// Ready returns with done_q, the cycle after the hit page or the last page is scanned; the pins answer one cycle later
		for (i = 0; i < 17000 && cmd_ready !== 1'b1; i++) begin
			@(posedge core_clk);
			#1;
		end
		chk("casc_hit", {71'h0, e[1] | p}, {71'h0, casc_hit});
		@(posedge core_clk);
		#1;
		chk("oe_flag_valid", {69'h0, e},
			{69'h0, flag_oe, search_success_flag, search_valid});
		chk("sram_addr", {48'h0, ea}, {48'h0, sram_addr});
		chk("sram_pins", {67'h0, pe}, {67'h0, ctl_oe, ce_n, we_n, ale_n, oe_n});
		@(posedge core_clk);
		nb_hit <= 1'b0;
		#1;
		chk("idle_flags", {68'h0, l, 2'h0, l},
			{68'h0, flag_oe, search_success_flag, search_valid, oe_n_oe});
	endtask
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 60000) begin
			num_errors++;
			wrap_up();
		end
	end
	initial begin
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		@(posedge core_clk);
		#1;
		t_id();
		t_burst();
		search(2'h0, 1'b0, 1'b0, 3'h7, 24'h000002, 5'h14);
		search(2'h1, 1'b0, 1'b1, 3'h7, 24'h002000, 5'h14);
		search(2'h2, 1'b0, 1'b1, 3'h7, 24'h004000, 5'h14);
		search(2'h3, 1'b0, 1'b1, 3'h5, 24'hFFFFFF, 5'h1F);
		search(2'h0, 1'b1, 1'b1, 3'h0, 24'hFFFFFF, 5'h0E);
		wrap_up();
	end
endmodule

// >>> verification/tsce_casc_model.sv
// Higher-priority cascaded neighbour seen on the cascade input
module tsce_casc_model (
	// Control and result
	input  wire logic hit_en,
	output logic      prior_hit
);
	timeunit 1ns;
	timeprecision 1ps;
	assign prior_hit = hit_en;
endmodule
